// ==== verilog/regacc_pkg.sv ====
// Purpose: shared constants for the process-image register access path
// Assumes: one logical channel of three bytes, control/status byte first
// Notes: register values are 16 bits, high byte sent before low byte
package regacc_pkg;
   localparam int unsigned REG_COUNT = 64;
   localparam logic [5:0] UNLOCK_CODE_WORD_IDX = 6'h1f;
   localparam logic [5:0] BEHAVIOUR_OPTIONS_IDX = 6'h20;
   localparam logic [15:0] UNLOCK_VALUE = 16'h1235;
   localparam logic [15:0] CODE_WORD_RESET = 16'h0000;
   localparam logic [15:0] USER_REG_RESET = 16'h0000;
   localparam int unsigned CTRL_REG_BIT = 7;
   localparam int unsigned CTRL_WRITE_BIT = 6;
   localparam int unsigned BYTE_CTRL = 0;
   localparam int unsigned BYTE_DATA_HIGH = 1;
   localparam int unsigned BYTE_DATA_LOW = 2;
   localparam logic [7:0] CTRL_IDLE = 8'h00;
   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_WAIT = 2'b01,
      HOST_DONE = 2'b11
   } host_state_type;
endpackage

// ==== verilog/regacc_if.sv ====
// Purpose: process image channel between controller and device
// Assumes: both ends on SYS_CLK
// Notes: image bytes in channel order, byte 0 is control or status
`timescale 1ns/10ps
interface regacc_if;
   logic [7:0] out_image [0:2];
   logic [7:0] in_image [0:2];
   modport device (input out_image, output in_image);
   modport host (output out_image, input in_image);
endinterface

// ==== verilog/regacc_device.sv ====
// Purpose: device end: register mode decode, user registers, code word gate
// Assumes: controller holds a control byte until it sees the receipt
// Notes: staged behaviour options become active only via ACTIVE_LOAD (power cycle); the code word acts at once
`timescale 1ns/10ps
//
// Contract
// RQ1: control bit7 set selects register mode
// RQ2: bit6 zero reads, one writes
// RQ3: read leaves register, returns value
// RQ4: controller waits for write receipt
// RQ5: index is control bits five to zero
// RQ6: status byte first, two data bytes follow
// RQ7: high data byte precedes low byte
// RQ8: read receipt equals control byte
// RQ9: write receipt is control without bit6
// RQ10: controller ignores data after write
// RQ11: read ignores output data word
// RQ12: only code word writable when protected
// RQ13: unlock value removes write protection
// RQ14: other code value restores protection
// RQ15: new values active after power cycle
// RQ16: code word reads back held value
// RQ17: bit7 zero gives status bit7 zero
// RQ18: protected writes leave registers unchanged
// RQ19: response stable while control byte held
module regacc_device
   import regacc_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // process image link
   regacc_if.device LINK,
   // process data side
   input wire logic [7:0] PD_STATUS,
   input wire logic [15:0] PD_IN_WORD,
   output logic [7:0] PD_CONTROL,
   output logic [15:0] PD_OUT_WORD,
   // configuration side
   input wire logic ACTIVE_LOAD,
   output logic [15:0] ACTIVE_OPTIONS,
   output logic UNLOCKED
);
   // storage for every index, with the next values beside it
   logic [15:0] regs [0:REG_COUNT-1];
   logic [15:0] next_regs [0:REG_COUNT-1];
   logic [REG_COUNT-1:0] reg_write;

   // receipt and data word returned on the link
   logic [7:0] status_byte;
   logic [7:0] next_status_byte;
   logic [15:0] in_word;
   logic [15:0] next_in_word;

   // last ordinary process data seen
   logic [7:0] pd_control;
   logic [7:0] next_pd_control;
   logic [15:0] pd_out_word;
   logic [15:0] next_pd_out_word;

   // options as used by the running logic
   logic [15:0] active_options;
   logic [15:0] next_active_options;

   // control byte decode
   logic [7:0] ctrl;
   logic [5:0] idx;
   logic [15:0] out_word;
   logic is_reg;
   logic is_write;
   logic unlocked;
   logic write_allowed;

   // control byte sits lowest, then the high and the low data byte
   assign ctrl = LINK.out_image[BYTE_CTRL]; // RQ6
   assign out_word = {
      LINK.out_image[BYTE_DATA_HIGH],
      LINK.out_image[BYTE_DATA_LOW]
   }; // RQ7
   assign idx = ctrl[5:0]; // RQ5
   assign is_reg = ctrl[CTRL_REG_BIT]; // RQ1
   assign is_write = ctrl[CTRL_WRITE_BIT]; // RQ2

   // protection is a plain compare, so any other code word relocks at once
   assign unlocked = (regs[UNLOCK_CODE_WORD_IDX] == UNLOCK_VALUE); // RQ13 RQ14

   // the code word stays writable, or a locked device could never be opened
   assign write_allowed = (idx == UNLOCK_CODE_WORD_IDX) || unlocked; // RQ12 RQ18

   // one word per index; all indices hold storage, so no read misses
   generate
      for (genvar g = 0; g < REG_COUNT; g++) begin : gen_reg
         assign reg_write[g] = is_reg && is_write && write_allowed && (idx == 6'(g));

         always_comb begin
            next_regs[g] = regs[g];

            // a held write repeats each cycle; harmless as the value is the same
            if (reg_write[g]) begin
               next_regs[g] = out_word;
            end
         end

         always_ff @(posedge SYS_CLK or posedge RST) begin
            if (RST) begin
               regs[g] <= (g == UNLOCK_CODE_WORD_IDX) ? CODE_WORD_RESET : USER_REG_RESET;
            end else begin
               regs[g] <= next_regs[g];
            end
         end
      end
   endgenerate

   // the reply is registered, so it answers one cycle after the control byte
   always_comb begin
      next_status_byte = status_byte;
      next_in_word = in_word;

      case ({is_reg, is_write})
         2'b11: begin
            // the data word after a write keeps its old value and means nothing
            next_status_byte = {ctrl[7], 1'b0, ctrl[5:0]}; // RQ9
         end
         2'b10: begin
            next_status_byte = ctrl; // RQ8 RQ19
            next_in_word = regs[idx]; // RQ3 RQ11 RQ16
         end
         2'b00, 2'b01: begin
            next_status_byte = {1'b0, PD_STATUS[6:0]}; // RQ17
            next_in_word = PD_IN_WORD;
         end
         default: begin
            // an unknown decode holds the last reply
            next_status_byte = status_byte;
         end
      endcase
   end

   // reply registers
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         status_byte <= CTRL_IDLE;
         in_word <= 16'h0000;
      end else begin
         status_byte <= next_status_byte;
         in_word <= next_in_word;
      end
   end

   // ordinary process data passes through only outside register mode
   always_comb begin
      next_pd_control = pd_control;
      next_pd_out_word = pd_out_word;

      if (!is_reg) begin
         next_pd_control = ctrl;
         next_pd_out_word = out_word;
      end
   end

   // process data registers
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pd_control <= CTRL_IDLE;
         pd_out_word <= 16'h0000;
      end else begin
         pd_control <= next_pd_control;
         pd_out_word <= next_pd_out_word;
      end
   end

   // staged options reach the logic only on a restart, never on the write itself
   always_comb begin
      next_active_options = active_options;

      if (ACTIVE_LOAD) begin
         next_active_options = regs[BEHAVIOUR_OPTIONS_IDX]; // RQ15
      end
   end

   // running options register
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         active_options <= USER_REG_RESET;
      end else begin
         active_options <= next_active_options;
      end
   end

   // reply bytes on the link
   assign LINK.in_image[BYTE_CTRL] = status_byte; // RQ6
   assign LINK.in_image[BYTE_DATA_HIGH] = in_word[15:8]; // RQ7
   assign LINK.in_image[BYTE_DATA_LOW] = in_word[7:0];

   // side outputs
   assign PD_CONTROL = pd_control;
   assign PD_OUT_WORD = pd_out_word;
   assign ACTIVE_OPTIONS = active_options;
   assign UNLOCKED = unlocked;
endmodule

// ==== verilog/regacc_host.sv ====
// Purpose: controller end: issues one register read or write, waits for receipt
// Assumes: device answers within some cycles; no timeout is kept
// Notes: REQ is taken only in idle; DONE pulses one cycle
`timescale 1ns/10ps
module regacc_host
   import regacc_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // process image link
   regacc_if.host LINK,
   // user request
   input wire logic REQ,
   input wire logic REQ_WRITE,
   input wire logic [5:0] REQ_INDEX,
   input wire logic [15:0] REQ_DATA,
   output logic BUSY,
   output logic DONE,
   output logic [15:0] READ_DATA
);
   host_state_type state, next_state;
   logic [7:0] ctrl, next_ctrl;
   logic [15:0] wdata, next_wdata;
   logic [15:0] rdata, next_rdata;
   logic [7:0] expect_status;

   assign expect_status = ctrl[CTRL_WRITE_BIT] ? {ctrl[7], 1'b0, ctrl[5:0]} : ctrl; // RQ8 RQ9

   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_wdata = wdata;
      next_rdata = rdata;
      case (state)
         HOST_IDLE: begin
            if (REQ) begin
               next_ctrl = {1'b1, REQ_WRITE, REQ_INDEX}; // RQ1 RQ2 RQ5
               next_wdata = REQ_DATA;
               next_state = HOST_WAIT;
            end
         end
         HOST_WAIT: begin
            // finished only once the receipt matches; a stale status is not taken
            if (LINK.in_image[BYTE_CTRL] == expect_status) begin // RQ4
               if (!ctrl[CTRL_WRITE_BIT]) begin // RQ10
                  next_rdata = {LINK.in_image[BYTE_DATA_HIGH], LINK.in_image[BYTE_DATA_LOW]}; // RQ7
               end
               next_state = HOST_DONE;
            end
         end
         HOST_DONE: begin
            next_ctrl = CTRL_IDLE;
            next_state = HOST_IDLE;
         end
         default: begin
            next_state = HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         state <= HOST_IDLE;
         ctrl <= CTRL_IDLE;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
      end else begin
         state <= next_state;
         ctrl <= next_ctrl;
         wdata <= next_wdata;
         rdata <= next_rdata;
      end
   end

   assign LINK.out_image[BYTE_CTRL] = ctrl; // RQ6
   assign LINK.out_image[BYTE_DATA_HIGH] = wdata[15:8];
   assign LINK.out_image[BYTE_DATA_LOW] = wdata[7:0];
   assign BUSY = (state != HOST_IDLE);
   assign DONE = (state == HOST_DONE);
   assign READ_DATA = rdata;
endmodule

// ==== tb/regacc_asserts.sv ====
// Purpose: link checks of the register access path
// Assumes: one clock, RST async active high
// Notes: code word shadow follows write requests seen on the link
`timescale 1ns/10ps
module regacc_asserts
   import regacc_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // link images
   input wire logic [7:0] out_image [0:2],
   input wire logic [7:0] in_image [0:2]
);
   logic [15:0] code;
   logic [7:0] ctl;
   assign ctl = out_image[0];
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) code <= CODE_WORD_RESET;
      else if (ctl == 8'hdf) code <= {out_image[1], out_image[2]};
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_read_receipt: assert property (ctl[7:6] == 2'b10 |=> in_image[0] == $past(ctl))
      else $error("read receipt wrong");
   a_write_receipt: assert property (ctl[7:6] == 2'b11 |=> in_image[0] == ($past(ctl) & 8'hbf))
      else $error("write receipt wrong");
   a_mode_echo: assert property (ctl[7] |=> in_image[0][7] && in_image[0][5:0] == $past(ctl[5:0]))
      else $error("mode or index not echoed");
   a_pd_ack: assert property (!ctl[7] |=> !in_image[0][7])
      else $error("process data ack wrong");
   a_code_read: assert property (ctl == 8'h9f |=> {in_image[1], in_image[2]} == $past(code))
      else $error("code word read wrong");
   a_read_stable: assert property (ctl[7:6] == 2'b10 && $stable(ctl) |=> $stable({in_image[1], in_image[2]}))
      else $error("read value moved");
   // a stale identical receipt ends the hold early; no toggle exists to tell them apart
   a_host_holds: assert property (ctl[7] && in_image[0] != (ctl[6] ? (ctl & 8'hbf) : ctl) |=> $stable(ctl))
      else $error("control dropped early");
   a_host_data: assert property (ctl[7:6] == 2'b11 && in_image[0] != (ctl & 8'hbf) |=> $stable({out_image[1], out_image[2]}))
      else $error("write data dropped early");
endmodule

// ==== tb/process_image_register_access_tb_top.sv ====
// Purpose: host and device joined, checked against a register model
// Assumes: all 64 indices hold storage
// Notes: stimulus on falling edges
`timescale 1ns/10ps
module process_image_register_access_tb_top
   import regacc_pkg::*;
;
   logic SYS_CLK = 1'b0, RST = 1'b1, REQ = 1'b0, REQ_WRITE = 1'b0, ACTIVE_LOAD = 1'b0;
   logic [5:0] REQ_INDEX = 6'h00;
   logic [15:0] REQ_DATA = 16'h0000, PD_IN_WORD = 16'h0000, READ_DATA, ACTIVE_OPTIONS;
   logic [7:0] PD_STATUS = 8'h00, PD_CONTROL;
   logic [15:0] PD_OUT_WORD;
   logic BUSY, DONE, UNLOCKED;
   int err_count = 0, comparisons = 0;
   int mem [64] = '{default: 0};
   initial begin
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   regacc_if i_regacc_if ();
   regacc_device i_regacc_device (.SYS_CLK(SYS_CLK), .RST(RST), .LINK(i_regacc_if),
      .PD_STATUS(PD_STATUS), .PD_IN_WORD(PD_IN_WORD), .PD_CONTROL(PD_CONTROL),
      .PD_OUT_WORD(PD_OUT_WORD),
      .ACTIVE_LOAD(ACTIVE_LOAD), .ACTIVE_OPTIONS(ACTIVE_OPTIONS), .UNLOCKED(UNLOCKED));
   regacc_host i_regacc_host (.SYS_CLK(SYS_CLK), .RST(RST), .LINK(i_regacc_if), .REQ(REQ),
      .REQ_WRITE(REQ_WRITE), .REQ_INDEX(REQ_INDEX), .REQ_DATA(REQ_DATA), .BUSY(BUSY),
      .DONE(DONE), .READ_DATA(READ_DATA));
   regacc_asserts i_regacc_asserts (.SYS_CLK(SYS_CLK), .RST(RST),
      .out_image(i_regacc_if.out_image), .in_image(i_regacc_if.in_image));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // read data is random too: the device must ignore it
   task automatic op(input logic w, input logic [5:0] idx, input logic [15:0] d);
      int n;
      REQ = 1'b1;
      REQ_WRITE = w;
      REQ_INDEX = idx;
      REQ_DATA = d;
      @(negedge SYS_CLK);
      REQ = 1'b0;
      n = 0;
      while (DONE !== 1'b1 && n < 20) begin
         @(negedge SYS_CLK);
         n++;
      end
      if (n == 20) begin
         err_count++;
         report_and_stop();
      end
      check("busy", {15'h0000, BUSY}, 16'h0001);
      check("receipt", {8'h00, i_regacc_if.in_image[0]}, {8'h00, 2'b10, idx});
      if (!w) check("read data", READ_DATA, 16'(mem[idx]));
      else if (idx == UNLOCK_CODE_WORD_IDX || mem[31] == UNLOCK_VALUE) mem[idx] = d;
      @(negedge SYS_CLK);
   endtask
   initial begin
      void'($urandom(32'h4a8027b2));
      repeat (16) @(negedge SYS_CLK);
      RST = 1'b0;
      PD_STATUS = 8'($urandom);
      PD_IN_WORD = 16'($urandom);
      repeat (2) @(negedge SYS_CLK);
      check("status", {8'h00, i_regacc_if.in_image[0]}, {8'h00, PD_STATUS & 8'h7f});
      check("pd word", {i_regacc_if.in_image[1], i_regacc_if.in_image[2]}, PD_IN_WORD);
      op(1'b1, 6'h20, 16'h0002);
      op(1'b0, 6'h20, 16'h5a5a);
      op(1'b1, 6'h1f, UNLOCK_VALUE);
      check("unlocked", {15'h0000, UNLOCKED}, 16'h0001);
      op(1'b1, 6'h20, 16'h0002);
      op(1'b0, 6'h20, 16'h0000);
      check("options early", ACTIVE_OPTIONS, 16'h0000);
      ACTIVE_LOAD = 1'b1;
      @(negedge SYS_CLK);
      ACTIVE_LOAD = 1'b0;
      @(negedge SYS_CLK);
      check("options loaded", ACTIVE_OPTIONS, 16'h0002);
      repeat (80) op(1'($urandom), ($urandom % 3 == 0) ? 6'h1f : 6'($urandom),
         ($urandom % 4 == 0) ? UNLOCK_VALUE : 16'($urandom));
      op(1'b1, 6'h1f, 16'h0000);
      check("relocked", {15'h0000, UNLOCKED}, 16'h0000);
      op(1'b0, 6'h1f, 16'hffff);
      PD_STATUS = 8'($urandom);
      @(negedge SYS_CLK);
      check("pd control", {8'h00, PD_CONTROL}, 16'h0000);
      check("pd out word", PD_OUT_WORD, 16'hffff);
      check("pd status", {8'h00, i_regacc_if.in_image[0]}, {8'h00, PD_STATUS & 8'h7f});
      report_and_stop();
   end
endmodule
